// >>> verilog/rsr_defines.svh
// Register offsets, field positions, reset values and timing counts of the status readout.
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH

// ============================================================
// Register offsets
`define RSR_OFS_REG_TIMER   6'h2b
`define RSR_OFS_PEAK        6'h2c
`define RSR_OFS_GAIN        6'h2d
`define RSR_OFS_RSVD_A      6'h2e

// ============================================================
// Field positions
`define RSR_REG_CODE_LSB    4
`define RSR_GPT_BIT         2
`define RSR_NRT_BIT         1
`define RSR_MRT_BIT         0
`define RSR_AM_LSB          4
`define RSR_PM_LSB          0

// ============================================================
// Reset values
`define RSR_REG_CODE_MAX    4'hf
`define RSR_PEAK_RST        8'h00
`define RSR_GAIN_RST        8'h00
`define RSR_RSVD_VALUE      8'h00

// ============================================================
// Timing
`define RSR_READ_LATENCY    1

`endif

// >>> verilog/rsr_pkg.sv
// Types shared by the status readout block.
package rsr_pkg;

  // Timer activity levels from the timer block.
  typedef struct packed {
    logic gpt_run;
    logic nrt_run;
    logic mrt_run;
  } rsr_timers_t;

  // Per-channel 4-bit codes.
  typedef struct packed {
    logic [3:0] am;
    logic [3:0] pm;
  } rsr_chan_pair_t;

  // Register access request from the serial port.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rsr_req_t;

  // Peak tracker states.
  typedef enum logic [1:0] {
    RSR_PK_IDLE  = 2'b01,
    RSR_PK_TRACK = 2'b10
  } rsr_pk_state_t;

endpackage

// >>> verilog/rsr_peak_hold.sv
// One 4-bit peak-hold nibble with clear.
`timescale 1ns/1ps
`include "rsr_defines.svh"

module rsr_peak_hold
#(
  parameter int WIDTH = 4
)
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // Control
  input  wire logic             clear_in,
  input  wire logic             sample_in,
  input  wire logic [WIDTH-1:0] code_in,
  // Result
  output logic      [WIDTH-1:0] peak_out
);

  logic [WIDTH-1:0] peak_reg;

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || clear_in)
      peak_reg <= '0;
    else if (sample_in && (code_in > peak_reg))
      peak_reg <= code_in;
  end

  assign peak_out = peak_reg;

  // ============================================================
  // Checks
  chk_peak_monotonic: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !$past(clear_in) && $past(rstn_in) |-> peak_reg >= $past(peak_reg))
    else $error("Peak nibble decreased without a clear.");

endmodule

// >>> verilog/rsr_status_regs.sv
// Read-only status register group: regulator, timers, signal peaks, gain reduction.
`timescale 1ns/1ps
`include "rsr_defines.svh"

module rsr_status_regs
(
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rstn_in,
  input  wire logic                   set_default_in,
  // Register access from the serial port
  input  wire rsr_pkg::rsr_req_t      req_in,
  output logic [7:0]                  rdata_out,
  output logic                        rvalid_out,
  output logic                        hit_out,
  // Regulator sources
  input  wire logic                   reg_src_ext_in,
  input  wire logic [3:0]             reg_ext_code_in,
  input  wire logic                   adjust_done_in,
  input  wire logic [3:0]             adjust_code_in,
  // Timer activity
  input  wire rsr_pkg::rsr_timers_t   timers_in,
  // Signal strength measurement
  input  wire logic                   rssi_valid_in,
  input  wire rsr_pkg::rsr_chan_pair_t rssi_code_in,
  input  wire logic                   msg_start_in,
  input  wire logic                   clear_peak_cmd_in,
  input  wire logic                   pm_select_in,
  // Gain reduction contributions
  input  wire rsr_pkg::rsr_chan_pair_t gain_static_in,
  input  wire rsr_pkg::rsr_chan_pair_t gain_squelch_in,
  input  wire rsr_pkg::rsr_chan_pair_t gain_agc_in,
  // Status views
  output logic                        chan_pm_out,
  output logic [7:0]                  peak_out
);
  import rsr_pkg::*;

  // ============================================================
  // Local state
  logic                 srst;
  logic [3:0]           adj_code_reg;
  logic [3:0]           reg_code;
  logic [2:0]           timers_reg;
  logic [3:0]           am_peak_bit_vec;
  logic [3:0]           pm_peak_bit_vec;
  logic                 clear_peak;
  rsr_chan_pair_t       gain_reg;
  rsr_chan_pair_t       gain_next;
  logic                 chan_pm_reg;
  rsr_pk_state_t        pk_state_reg;
  rsr_pk_state_t        pk_state_next;
  logic [7:0]           rdata_reg;
  logic [7:0]           rdata_next;
  logic                 rvalid_reg;

  assign srst = !rstn_in || set_default_in;

  // Saturating 4-bit sum used by both channels.
  function automatic logic [3:0] sat_add3(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
    logic [5:0] s;
    s = {2'b00, a} + {2'b00, b} + {2'b00, c};
    sat_add3 = (s > 6'h0f) ? 4'hf : s[3:0];
  endfunction

  // Address match inside this group.
  function automatic logic in_group(input logic [5:0] a);
    in_group = (a >= `RSR_OFS_REG_TIMER) && (a <= `RSR_OFS_RSVD_A);
  endfunction

  // ============================================================
  // Regulator code
  // Reset to top code.
  always_ff @(posedge clk_in)
  begin
    if (srst)
      adj_code_reg <= `RSR_REG_CODE_MAX;
    else if (adjust_done_in)
      adj_code_reg <= adjust_code_in;
  end

  assign reg_code = reg_src_ext_in ? reg_ext_code_in : adj_code_reg;

  // ============================================================
  // Timer flags
  // The flags follow the timers with one cycle of delay to align with read data.
  // Timer running flags.
  always_ff @(posedge clk_in)
  begin
    if (srst)
      timers_reg <= 3'h0;
    else
      timers_reg <= {timers_in.gpt_run, timers_in.nrt_run, timers_in.mrt_run};
  end

  // ============================================================
  // Peak tracking
  // Clear sources.
  assign clear_peak = srst || msg_start_in || clear_peak_cmd_in;

  always_comb
  begin
    pk_state_next = pk_state_reg;
    case (pk_state_reg)
      RSR_PK_IDLE:  if (rssi_valid_in && !clear_peak) pk_state_next = RSR_PK_TRACK;
      RSR_PK_TRACK: if (clear_peak) pk_state_next = RSR_PK_IDLE;
      default:      pk_state_next = RSR_PK_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (srst)
      pk_state_reg <= RSR_PK_IDLE;
    else
      pk_state_reg <= pk_state_next;
  end

  rsr_peak_hold #(.WIDTH(4)) u_am_peak
  (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .clear_in  (clear_peak),
    .sample_in (rssi_valid_in),
    .code_in   (rssi_code_in.am),
    .peak_out  (am_peak_bit_vec)
  );

  rsr_peak_hold #(.WIDTH(4)) u_pm_peak
  (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .clear_in  (clear_peak),
    .sample_in (rssi_valid_in),
    .code_in   (rssi_code_in.pm),
    .peak_out  (pm_peak_bit_vec)
  );

  assign peak_out = {am_peak_bit_vec, pm_peak_bit_vec};

  always_ff @(posedge clk_in)
  begin
    if (srst)
      chan_pm_reg <= 1'b0;
    else
      chan_pm_reg <= pm_select_in;
  end

  assign chan_pm_out = chan_pm_reg;

  // ============================================================
  // Gain reduction
  // Saturating combination, since the nibble cannot show more than 15 steps.
  always_comb
  begin
    gain_next.am = sat_add3(gain_static_in.am, gain_squelch_in.am, gain_agc_in.am);
    gain_next.pm = sat_add3(gain_static_in.pm, gain_squelch_in.pm, gain_agc_in.pm);
  end

  always_ff @(posedge clk_in)
  begin
    if (srst)
      gain_reg <= `RSR_GAIN_RST;
    else
      gain_reg <= gain_next;
  end

  // ============================================================
  // Read port
  always_comb
  begin
    rdata_next = 8'h00;
    case (req_in.addr)
      `RSR_OFS_REG_TIMER: rdata_next = {reg_code, 1'b0, timers_reg};
      `RSR_OFS_PEAK:      rdata_next = {am_peak_bit_vec, pm_peak_bit_vec};
      `RSR_OFS_GAIN:      rdata_next = {gain_reg.am, gain_reg.pm};
      `RSR_OFS_RSVD_A:    rdata_next = `RSR_RSVD_VALUE;
      default:            rdata_next = 8'h00;
    endcase
  end

  // Only reads are served; writes have no path into state.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      rdata_reg <= 8'h00;
    else if (req_in.rd && in_group(req_in.addr))
      rdata_reg <= rdata_next;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      rvalid_reg <= 1'b0;
    else
      rvalid_reg <= req_in.rd && in_group(req_in.addr);
  end

  assign rdata_out  = rdata_reg;
  assign rvalid_out = rvalid_reg;
  assign hit_out    = in_group(req_in.addr);

  // ============================================================
  // Checks
  chk_reg_code_reset: assert property (@(posedge clk_in)
    $past(srst) && !reg_src_ext_in |-> reg_code == `RSR_REG_CODE_MAX)
    else $error("Regulator code not at maximum after reset.");

  chk_reg_source_ext: assert property (@(posedge clk_in) disable iff (!rstn_in)
    reg_src_ext_in |-> reg_code == reg_ext_code_in)
    else $error("External regulator code not reported.");

  chk_gpt_flag: assert property (@(posedge clk_in) disable iff (srst)
    $past(timers_in.gpt_run) && !$past(srst) |-> timers_reg[`RSR_GPT_BIT])
    else $error("General timer flag missing.");

  chk_nrt_flag: assert property (@(posedge clk_in) disable iff (srst)
    !$past(srst) |-> timers_reg[`RSR_NRT_BIT] == $past(timers_in.nrt_run))
    else $error("No-response timer flag wrong.");

  chk_mrt_flag: assert property (@(posedge clk_in) disable iff (srst)
    !$past(srst) |-> timers_reg[`RSR_MRT_BIT] == $past(timers_in.mrt_run))
    else $error("Mask timer flag wrong.");

  chk_peak_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
    clear_peak |=> peak_out == 8'h00)
    else $error("Peaks not cleared.");

  chk_gain_reset: assert property (@(posedge clk_in)
    $past(srst) |-> gain_reg == 8'h00 && peak_out == 8'h00)
    else $error("Gain or peak not zero after reset.");

  chk_gain_combine: assert property (@(posedge clk_in) disable iff (srst)
    ##1 !$past(srst) |-> gain_reg.am >= $past(gain_static_in.am))
    else $error("Gain below static reduction.");

  sequence s_read_gain;
    req_in.rd && req_in.addr == `RSR_OFS_GAIN;
  endsequence

  chk_read_gain: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_read_gain |=> rvalid_out && rdata_out == $past({gain_reg.am, gain_reg.pm}))
    else $error("Gain read data wrong.");

  sequence s_read_regtimer;
    req_in.rd && req_in.addr == `RSR_OFS_REG_TIMER;
  endsequence

  sequence s_read_peak;
    req_in.rd && req_in.addr == `RSR_OFS_PEAK;
  endsequence

  sequence s_read_rsvd;
    req_in.rd && req_in.addr == `RSR_OFS_RSVD_A;
  endsequence

  chk_reg_code_field: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_read_regtimer |=> rdata_out[7:4] == $past(reg_code))
    else $error("Regulator code field wrong.");

  chk_timer_field: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_read_regtimer |=> rdata_out[3:0] == $past({1'b0, timers_reg}))
    else $error("Timer field wrong.");

  chk_reg_source_adj: assert property (@(posedge clk_in) disable iff (srst)
    adjust_done_in |=> adj_code_reg == $past(adjust_code_in))
    else $error("Adjusted regulator code not taken.");

  chk_read_peak: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_read_peak |=> rvalid_out && rdata_out == $past(peak_out))
    else $error("Peak read data wrong.");

  chk_am_peak_rise: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !$past(clear_peak) && $past(rssi_valid_in) && $past(rssi_code_in.am) > $past(am_peak_bit_vec)
    |-> am_peak_bit_vec == $past(rssi_code_in.am))
    else $error("AM peak not raised.");

  chk_pm_peak_rise: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !$past(clear_peak) && $past(rssi_valid_in) && $past(rssi_code_in.pm) > $past(pm_peak_bit_vec)
    |-> pm_peak_bit_vec == $past(rssi_code_in.pm))
    else $error("PM peak not raised.");

  chk_chan_select: assert property (@(posedge clk_in) disable iff (srst)
    !$past(srst) |-> chan_pm_out == $past(pm_select_in))
    else $error("Channel in use not reported.");

  chk_read_rsvd: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_read_rsvd |=> rvalid_out && rdata_out == 8'h00)
    else $error("Reserved slot read wrong.");

  chk_hit_decode: assert property (@(posedge clk_in) disable iff (!rstn_in)
    hit_out == ((req_in.addr >= 6'h2b) && (req_in.addr <= 6'h2e)))
    else $error("Group address decode wrong.");

  chk_write_ignored: assert property (@(posedge clk_in) disable iff (!rstn_in)
    req_in.wr && !req_in.rd |=> !rvalid_out)
    else $error("Write produced a read answer.");

  chk_write_no_data: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(req_in.rd && hit_out) |=> $stable(rdata_out))
    else $error("Read data moved without a read.");

  chk_clear_idle: assert property (@(posedge clk_in) disable iff (!rstn_in)
    clear_peak |=> pk_state_reg == RSR_PK_IDLE)
    else $error("Tracker not idle after clear.");

  // Idle means nothing has been sampled since the last clear, so both peaks must be zero.
  chk_track_idle: assert property (@(posedge clk_in) disable iff (!rstn_in)
    pk_state_reg == RSR_PK_IDLE |-> peak_out == 8'h00)
    else $error("Peaks nonzero while tracker idle.");

  chk_gain_pm_floor: assert property (@(posedge clk_in) disable iff (srst)
    ##1 !$past(srst) |-> gain_reg.pm >= $past(gain_static_in.pm))
    else $error("PM gain below static reduction.");

  chk_peak_reset: assert property (@(posedge clk_in)
    $past(!rstn_in) |-> peak_out == 8'h00 && rdata_out == 8'h00 && !rvalid_out)
    else $error("Outputs not zero after reset.");

endmodule

// >>> bench/rsr_host.sv
// Host model that reaches the status group through the register port.
`timescale 1ns/1ps
module rsr_host
(
  // Clock and answer
  input  wire logic         clk_in,
  input  wire logic [7:0]   rdata_in,
  input  wire logic         rvalid_in,
  // Request
  output rsr_pkg::rsr_req_t req_out
);
  import rsr_pkg::*;
  initial req_out = '0;
  // ============================================================
  // Access
  // One request pulse, answer taken 1 ns after the taking edge.
  task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
  begin
    @(posedge clk_in);
    #1;
    req_out = {~wr, wr, addr, wd};
    @(posedge clk_in);
    #1;
    req_out = '0;
    ok = rvalid_in;
    rd = rdata_in;
  end
  endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the read-only status register group.
`timescale 1ns/1ps
module tb_top;
  import rsr_pkg::*;
  logic           clk_in = 1'b0;
  logic           rstn_in = 1'b0;
  logic           set_default_in, reg_src_ext_in, adjust_done_in, rssi_valid_in;
  logic           msg_start_in, clear_peak_cmd_in, pm_select_in, rvalid_out, hit_out, chan_pm_out, ok;
  logic [3:0]     reg_ext_code_in, adjust_code_in, am_pk, pm_pk;
  logic [7:0]     rdata_out, peak_out, rd;
  rsr_req_t       req_in;
  rsr_timers_t    timers_in;
  rsr_chan_pair_t rssi_code_in, gain_static_in, gain_squelch_in, gain_agc_in;
  int             fail_count, tests_run, seed;

  initial forever #12.5 clk_in = ~clk_in;

  rsr_host u_rsr_host (.clk_in(clk_in), .rdata_in(rdata_out), .rvalid_in(rvalid_out), .req_out(req_in));

  rsr_status_regs u_rsr_status_regs (.clk_in(clk_in), .rstn_in(rstn_in), .set_default_in(set_default_in),
    .req_in(req_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .hit_out(hit_out),
    .reg_src_ext_in(reg_src_ext_in), .reg_ext_code_in(reg_ext_code_in), .adjust_done_in(adjust_done_in),
    .adjust_code_in(adjust_code_in), .timers_in(timers_in), .rssi_valid_in(rssi_valid_in),
    .rssi_code_in(rssi_code_in), .msg_start_in(msg_start_in), .clear_peak_cmd_in(clear_peak_cmd_in),
    .pm_select_in(pm_select_in), .gain_static_in(gain_static_in), .gain_squelch_in(gain_squelch_in),
    .gain_agc_in(gain_agc_in), .chan_pm_out(chan_pm_out), .peak_out(peak_out));

  // ============================================================
  // Helpers
  // Saturating sum, since the reduction cannot exceed the 4-bit range.
  function automatic logic [3:0] sat(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
    logic [5:0] s;
    s = a + b + c;
    return (s > 6'h0f) ? 4'hf : s[3:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task automatic rdreg(input logic [5:0] addr, input logic [7:0] exp);
  begin
    u_rsr_host.access(1'b0, addr, 8'h00, rd, ok);
    check({7'h00, ok}, 8'h01);
    check(rd, exp);
  end
  endtask

  task automatic tick;
  begin
    @(posedge clk_in);
    #1;
  end
  endtask

  task automatic finish_test;
  begin
    $display("fail_count %0d tests_run %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    finish_test;
  end

  // ============================================================
  // Main sequence
  initial
  begin
    seed = 45728;
    {set_default_in, reg_src_ext_in, adjust_done_in, rssi_valid_in, msg_start_in} = '0;
    {clear_peak_cmd_in, pm_select_in, reg_ext_code_in, adjust_code_in, timers_in} = '0;
    {rssi_code_in, gain_static_in, gain_squelch_in, gain_agc_in} = '0;
    repeat (4) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    rdreg(6'h2b, 8'hf0);
    rdreg(6'h2c, 8'h00);
    rdreg(6'h2d, 8'h00);
    rdreg(6'h2e, 8'h00);
    for (int t = 0; t < 8; t++)
    begin
      timers_in = t[2:0];
      rdreg(6'h2b, {5'h1e, t[2:0]});
    end
    timers_in = '0;
    reg_ext_code_in = 4'($random(seed));
    reg_src_ext_in = 1'b1;
    rdreg(6'h2b, {reg_ext_code_in, 4'h0});
    reg_src_ext_in = 1'b0;
    adjust_code_in = 4'($random(seed));
    adjust_done_in = 1'b1;
    tick;
    adjust_done_in = 1'b0;
    rdreg(6'h2b, {adjust_code_in, 4'h0});
    am_pk = 4'h0;
    pm_pk = 4'h0;
    for (int i = 0; i < 40; i++)
    begin
      pm_select_in = i[0];
      rssi_code_in = 8'($random(seed));
      rssi_valid_in = 1'b1;
      tick;
      rssi_valid_in = 1'b0;
      am_pk = (rssi_code_in.am > am_pk) ? rssi_code_in.am : am_pk;
      pm_pk = (rssi_code_in.pm > pm_pk) ? rssi_code_in.pm : pm_pk;
      rdreg(6'h2c, {am_pk, pm_pk});
      check(peak_out, {am_pk, pm_pk});
      check({7'h00, chan_pm_out}, {7'h00, i[0]});
    end
    // A clear that lands with a sample must win.
    for (int k = 0; k < 2; k++)
    begin
      rssi_code_in = 8'($random(seed)) | 8'h11;
      rssi_valid_in = 1'b1;
      msg_start_in = (k == 0);
      clear_peak_cmd_in = (k == 1);
      tick;
      {rssi_valid_in, msg_start_in, clear_peak_cmd_in} = 3'h0;
      rdreg(6'h2c, 8'h00);
    end
    for (int i = 0; i < 30; i++)
    begin
      {gain_static_in, gain_squelch_in, gain_agc_in} = 24'($random(seed));
      rdreg(6'h2d, {sat(gain_static_in.am, gain_squelch_in.am, gain_agc_in.am),
                    sat(gain_static_in.pm, gain_squelch_in.pm, gain_agc_in.pm)});
    end
    for (int a = 8'h2b; a < 8'h2f; a++)
    begin
      u_rsr_host.access(1'b1, a[5:0], 8'(a) ^ 8'h5a, rd, ok);
      check({7'h00, ok}, 8'h00);
    end
    rdreg(6'h2b, {adjust_code_in, 4'h0});
    rdreg(6'h2c, 8'h00);
    u_rsr_host.access(1'b0, 6'h2f, 8'h00, rd, ok);
    check({7'h00, ok}, 8'h00);
    {gain_static_in, gain_squelch_in, gain_agc_in} = '0;
    rssi_code_in = 8'h77;
    rssi_valid_in = 1'b1;
    tick;
    rssi_valid_in = 1'b0;
    set_default_in = 1'b1;
    tick;
    set_default_in = 1'b0;
    rdreg(6'h2b, 8'hf0);
    rdreg(6'h2c, 8'h00);
    rdreg(6'h2d, 8'h00);
    finish_test;
  end
endmodule
